// File: dv/ssr_receiver_tb.sv
// Self-checking bench for the synchronous serial receiver.
// Assumes the receiver, its map header, the peer and the monitor are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver_tb;
  localparam logic [31:0] BASE = 32'h47; // Port, sync, master, high speed
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, r;
  logic ack, data_o, data_oe, ck_o, ck_oe, irq, pdata, pclk, ck_d;
  int num_errors = 0;
  int tests_run = 0;
  int edges = 0;
  int e0;
  always #10 clk = ~clk;
  // Count master clock pulses
  always @(posedge clk) begin
    ck_d <= ck_o;
    if (ck_o && !ck_d) edges <= edges + 1;
  end
  ssr_receiver ssr_receiver_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .data_pin_i(pdata), .data_pin_o(data_o), .data_pin_oe(data_oe), .clk_pin_i(pclk),
    .clk_pin_o(ck_o), .clk_pin_oe(ck_oe), .irq(irq));
  ssr_rx_peer ssr_rx_peer_inst (.clk_m(ck_o), .data(pdata), .clk_s(pclk));
  // ****
  // Shared tasks
  // ****
  task automatic results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin num_errors++; results(); end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin bus(1'b0, 6'h04, 32'h0); n++; end while ((r & m) !== v && n < 500);
    if ((r & m) !== v) begin num_errors++; results(); end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic reset_vals;
    rd(6'h00, 32'hFFFFFFFF, 32'h0);
    rd(6'h04, 32'h1E, 32'h0);
    rd(6'h1C, 32'hFFFFFFFF, 32'h0);
    chk(data_oe, 32'h0);
  endtask
  task automatic single_shot;
    bus(1'b1, 6'h0C, 32'h7);
    bus(1'b1, 6'h00, BASE);
    ssr_rx_peer_inst.load(36'hA5, 8);
    e0 = edges;
    bus(1'b1, 6'h00, BASE | 32'h8);
    wait_stat(32'h4, 32'h4);
    rd(6'h00, 32'hFF, BASE);
    chk(edges - e0, 32'h8);
    chk(irq, 32'h0);
    rd(6'h10, 32'h1, 32'h1);
    rd(6'h04, 32'h1E, 32'h0C);
    rd(6'h08, 32'hFF, 32'hA5);
    rd(6'h04, 32'h1E, 32'h0);
    bus(1'b1, 6'h18, 32'h3);
  endtask
  task automatic overrun;
    logic [7:0] ch [3] = '{8'h11, 8'h22, 8'h33};
    logic [31:0] st [3] = '{32'h08, 32'h10, 32'h12};
    bus(1'b1, 6'h14, 32'h1);
    for (int i = 0; i < 3; i++) begin
      ssr_rx_peer_inst.load({28'h0, ch[i]}, 8);
      bus(1'b1, 6'h00, BASE | 32'h8);
      wait_stat(32'h1A, st[i]);
    end
    chk(irq, 32'h1);
    rd(6'h10, 32'h2, 32'h2);
    bus(1'b1, 6'h18, 32'h1);
    rd(6'h10, 32'h1, 32'h0);
    chk(irq, 32'h0);
    rd(6'h08, 32'hFF, 32'h11);
    rd(6'h04, 32'h1A, 32'h08);
    rd(6'h08, 32'hFF, 32'h22);
    rd(6'h04, 32'h1E, 32'h0);
    bus(1'b1, 6'h14, 32'h0);
    bus(1'b1, 6'h18, 32'h3);
  endtask
  task automatic cont_ninth;
    ssr_rx_peer_inst.load({9'h155, 9'h0AA, 9'h0F0, 9'h1C3}, 36);
    bus(1'b1, 6'h00, BASE | 32'h38);
    wait_stat(32'h18, 32'h10);
    rd(6'h00, 32'hFF, BASE | 32'h30);
    bus(1'b1, 6'h00, BASE | 32'h20);
    ssr_rx_peer_inst.load(36'h0, 0);
    e0 = edges;
    repeat (100) @(posedge clk);
    chk(edges - e0, 32'h0);
    rd(6'h00, 32'hFF, BASE | 32'h20);
    rd(6'h04, 32'h1B, 32'h11);
    rd(6'h08, 32'hFF, 32'hC3);
    rd(6'h04, 32'h19, 32'h08);
    rd(6'h08, 32'hFF, 32'hF0);
    rd(6'h04, 32'h1E, 32'h0);
  endtask
  task automatic slave;
    bus(1'b1, 6'h00, 32'h13);
    @(posedge clk);
    chk(ck_oe, 32'h0);
    #7;
    ssr_rx_peer_inst.slave_frame(9'h05A, 8);
    wait_stat(32'h4, 32'h4);
    rd(6'h08, 32'hFF, 32'h5A);
    bus(1'b1, 6'h00, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    reset_vals();
    single_shot();
    overrun();
    cont_ninth();
    slave();
    results();
  end
endmodule // ssr_receiver_tb
bind ssr_receiver ssr_rx_monitor ssr_rx_monitor_inst (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .data_pin_oe(data_pin_oe), .clk_pin_o(clk_pin_o),
  .clk_pin_oe(clk_pin_oe), .irq(irq));
`default_nettype wire

// File: dv/ssr_rx_monitor.sv
// Port checker for the synchronous serial receiver.
// Assumes a bind onto ssr_receiver; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ssr_rx_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and interrupt
  input wire logic data_pin_oe,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe,
  input wire logic irq
);
  logic [7:0] ctrl_q;
  logic en_q;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Shadow of control and enable; hardware clears single-shot, so the shadow only over-states it
  always @(posedge clk) begin
    if (reset) begin
      ctrl_q <= 8'h00;
      en_q <= 1'b0;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == 6'h00) ctrl_q <= wb_dat_i[7:0];
      if (wb_adr_i == 6'h14) en_q <= |wb_dat_i[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // Assertions
  // ****
  AST_DATA_DRV_OFF: assert property (!data_pin_oe)
    else $error("data pin driven");
  AST_SLAVE_CLK_OFF: assert property ((!ctrl_q[2] && $past(!ctrl_q[2])) |-> !clk_pin_oe)
    else $error("clock pin driven in slave mode");
  AST_CLK_DRIVEN: assert property (clk_pin_o |-> clk_pin_oe)
    else $error("clock high while undriven");
  AST_NO_ENABLE_NO_CLK: assert property ((ctrl_q[4:3] == 2'h0 && $past(ctrl_q[4:3]) == 2'h0) |-> !$rose(clk_pin_o))
    else $error("clock without enable");
  AST_CLK_STOP: assert property (($fell(ctrl_q[4]) && !ctrl_q[3]) |-> ##[0:2] !clk_pin_o)
    else $error("clock not stopped");
  AST_IRQ_MASKED: assert property ((!en_q && $past(!en_q)) |-> !irq)
    else $error("irq while disabled");
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_UNMAPPED_ZERO: assert property ((req && !wb_we_i && wb_adr_i[5:2] > 4'h6) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Main scenarios reached
  COV_IRQ: cover property ($rose(irq));
  COV_CLK: cover property ($rose(clk_pin_o));
  COV_READ: cover property (wb_ack_o && !wb_we_i);
endmodule // ssr_rx_monitor
`default_nettype wire

// File: dv/ssr_rx_peer.sv
// Peer serial device: feeds data in master mode, makes the clock in slave mode.
// Assumes a 160 ns link clock that stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module ssr_rx_peer (
  // Clock from the receiver
  input wire logic clk_m,
  // Lines towards the receiver
  output logic data,
  output logic clk_s
);
  logic [35:0] stream = 36'h0;
  int left = 0;
  initial data = 1'b0;
  initial clk_s = 1'b0;
  // Next bit on the leading edge so it holds over the trailing one
  always @(posedge clk_m) begin
    if (left > 0) begin
      data <= stream[0];
      stream <= stream >> 1;
      left <= left - 1;
    end
  end
  // Hold time gone after the frame: line no longer keeps the last bit
  always @(negedge clk_m) begin
    if (left == 0) data <= ~data;
  end
  task automatic load(input logic [35:0] s, input int n);
    stream = s;
    left = n;
  endtask
  // Only as many clocks as the character has bits
  task automatic slave_frame(input logic [8:0] ch, input int n);
    for (int i = 0; i < n; i++) begin
      clk_s = 1'b1;
      data = ch[i];
      #80;
      clk_s = 1'b0;
      #80;
    end
    data = ~data;
  endtask
endmodule // ssr_rx_peer
`default_nettype wire

// File: logic/ssr_edge_sync.v
// Two-flop synchroniser with rise and fall detection for one pin.
// Assumes an asynchronous pin and a single system clock.
`timescale 1ns/1ps
`default_nettype none
module ssr_edge_sync (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Pin side
  input wire pin,
  // Synchronised level and edges
  output reg level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg last_q;

  // ****************************************
  // Synchroniser
  // ****************************************
  // First flop feeds only the second
  always @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      level <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      level <= meta_q;
      last_q <= level;
    end
  end

  // Edges seen on the settled level
  assign rise = level & ~last_q;
  assign fall = ~level & last_q;
endmodule // ssr_edge_sync
`default_nettype wire

// File: logic/ssr_map.vh
// Register map, field positions and reset values of the synchronous serial receiver.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
// Notes on behaviour
// RULE1: As master receiver the data pin driver is always switched off.
// RULE2: Reception starts when single-shot or continuous enable is set.
// RULE3: Single-shot makes one clock per bit, then hardware clears single-shot.
// RULE4: Continuous clocks until cleared; clearing mid-character stops clock, drops partial.
// RULE5: Both set: single-shot clears after first character, continuous carries on.
// RULE6: Data pin is sampled on the trailing clock edge into the shift register.
// RULE7: A full character sets the pending flag and moves into a two-deep FIFO.
// RULE8: Data register shows oldest low byte; pending stays while FIFO is non-empty.
// RULE9: In slave mode the clock comes from the pin and its driver is off.
// RULE10: Data changes on leading edge, valid at trailing edge, one bit per clock.
// RULE11: A peer master gives only as many clocks as the character has bits.
// RULE12: A third character with the FIFO full sets overrun and keeps the FIFO.
// RULE13: During overrun both characters stay readable, no new character is taken.
// RULE14: Single-shot overrun clears on data read; continuous by enable or port clear.
// RULE15: Ninth-bit mode shifts nine bits; ninth bit shows oldest character's top bit.
// RULE16: Software reads the ninth bit before the data register, which pops the FIFO.
// RULE17: Software sets divisor, select bits and enables before starting reception.
// RULE18: Pending flag sets regardless; interrupt only when the receive enable allows.
// RULE19: Without ninth-bit mode a character has eight bits; ninth bit meaningless.
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define SSR_OFS_CTRL 6'h00
`define SSR_OFS_STAT 6'h04
`define SSR_OFS_DATA 6'h08
`define SSR_OFS_BAUD 6'h0C
`define SSR_OFS_IRQ_STAT 6'h10
`define SSR_OFS_IRQ_EN 6'h14
`define SSR_OFS_IRQ_CLR 6'h18

// ****************************************
// Control fields
// ****************************************
`define SSR_CTRL_SERIAL_PORT_ENABLE 0
`define SSR_CTRL_SYNC 1
`define SSR_CTRL_MASTER 2
`define SSR_CTRL_SINGLE 3
`define SSR_CTRL_CONT 4
`define SSR_CTRL_NINE 5
`define SSR_CTRL_HISPEED 6
`define SSR_CTRL_WIDE 7

// ****************************************
// Status fields and interrupt bits
// ****************************************
`define SSR_STAT_NINTH 0
`define SSR_STAT_OVERRUN_ERROR_FLAG 1
`define SSR_STAT_PEND 2
`define SSR_STAT_CNT_LO 3
`define SSR_IRQ_RX 0
`define SSR_IRQ_OV 1

// ****************************************
// Reset values and widths
// ****************************************
`define SSR_CTRL_RST 8'h00
`define SSR_BAUD_RST 16'h0000
`define SSR_BITS_8 4'h8
`define SSR_BITS_9 4'h9
`define SSR_FIFO_FULL 2'h2

`endif

// File: logic/ssr_receiver.v
// Receive path of a synchronous serial port: master or slave clock, two-deep FIFO.
// Assumes a classic Wishbone master on clk and a peer device on the data and clock pins.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_map.vh"
module ssr_receiver (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Data pin
  input wire data_pin_i,
  output reg data_pin_o,
  output reg data_pin_oe,
  // Clock pin
  input wire clk_pin_i,
  output reg clk_pin_o,
  output reg clk_pin_oe,
  // Interrupt
  output reg irq
);
  // Phase states of the master clock generator
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOW = 2'b01;
  localparam [1:0] ST_HIGH = 2'b10;

  reg [7:0] ctrl_q;
  reg [15:0] baud_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg [8:0] fifo_q [0:1];
  reg [1:0] cnt_q;
  reg overrun_error_flag_q;
  reg [8:0] shift_q;
  reg [3:0] nbits_q;
  reg [1:0] st_q;
  reg [17:0] div_q;
  reg clk_out_q;
  wire data_lvl;
  wire ck_lvl;
  wire ck_rise;
  wire ck_fall;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  ssr_edge_sync u_data (
    .clk(clk),
    .reset(reset),
    .pin(data_pin_i),
    .level(data_lvl),
    .rise(),
    .fall()
  );

  ssr_edge_sync u_clk (
    .clk(clk),
    .reset(reset),
    .pin(clk_pin_i),
    .level(ck_lvl),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Register hit for a given word offset
  function hit;
    input [5:0] adr;
    input [5:0] ofs;
    begin
      hit = (adr[5:2] == ofs[5:2]);
    end
  endfunction

  wire serial_port_enable = ctrl_q[`SSR_CTRL_SERIAL_PORT_ENABLE];
  wire sync_mode = ctrl_q[`SSR_CTRL_SYNC];
  wire master = ctrl_q[`SSR_CTRL_MASTER];
  wire single = ctrl_q[`SSR_CTRL_SINGLE];
  wire cont = ctrl_q[`SSR_CTRL_CONT];
  wire nine = ctrl_q[`SSR_CTRL_NINE];
  wire active = serial_port_enable & sync_mode;
  wire rx_on = active & (single | cont) & ~overrun_error_flag_q; // RULE2 RULE13
  wire [3:0] char_bits = nine ? `SSR_BITS_9 : `SSR_BITS_8; // RULE15 RULE19

  // Word selects shared by the write and pop paths
  wire sel_ctrl = hit(wb_adr_i, `SSR_OFS_CTRL);
  wire sel_data = hit(wb_adr_i, `SSR_OFS_DATA);
  wire sel_irq_en = hit(wb_adr_i, `SSR_OFS_IRQ_EN);
  wire sel_irq_clr = hit(wb_adr_i, `SSR_OFS_IRQ_CLR);

  // A request counts once: the ack cycle itself is not a new request
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_data = bus_req & ~wb_we_i & sel_data;
  wire wr_ctrl = wr & sel_ctrl;

  // Divider reload: 4 x low baud byte + 4 by default; wide reloads the 16-bit baud + 1, high-speed the low byte + 1
  reg [17:0] half_period;
  always @* begin
    half_period = {8'h00, baud_q[7:0], 2'b00} + 18'h00004;
    if (ctrl_q[`SSR_CTRL_WIDE]) begin
      half_period = {2'b00, baud_q} + 18'h00001;
    end else if (ctrl_q[`SSR_CTRL_HISPEED]) begin
      half_period = {10'h000, baud_q[7:0]} + 18'h00001;
    end
  end

  // Trailing edge: own falling edge as master, pin falling edge as slave
  wire master_trail = (st_q == ST_HIGH) && (div_q == 18'h00000);
  wire trail = master ? master_trail : ck_fall; // RULE6 RULE9 RULE10
  wire sample = rx_on & trail;
  wire last_bit = sample && (nbits_q + 4'h1 == char_bits);
  wire [8:0] next_shift = nine ? {data_lvl, shift_q[8:1]} : {1'b0, data_lvl, shift_q[7:1]};
  wire full = (cnt_q == `SSR_FIFO_FULL);
  wire push = last_bit & ~full; // RULE7
  wire pop = rd_data & (cnt_q != 2'h0);
  wire ovr_set = last_bit & full; // RULE12
  // Continuous clear mid-character drops partial bits
  wire abort = ~rx_on | (wr_ctrl & ~wb_dat_i[`SSR_CTRL_CONT] & ~wb_dat_i[`SSR_CTRL_SINGLE]);

  // ****************************************
  // Control and baud registers
  // ****************************************
  // Hardware clear of single-shot beats a simultaneous software write of the same bit
  always @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `SSR_CTRL_RST;
      baud_q <= `SSR_BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (wr & hit(wb_adr_i, `SSR_OFS_BAUD)) begin
        baud_q <= wb_dat_i[15:0];
      end
      if (last_bit & single) begin
        ctrl_q[`SSR_CTRL_SINGLE] <= 1'b0; // RULE3 RULE5
      end
    end
  end

  // ****************************************
  // Shift register and bit counter
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      shift_q <= 9'h000;
      nbits_q <= 4'h0;
    end else if (abort) begin
      nbits_q <= 4'h0; // RULE4
    end else if (sample) begin
      shift_q <= next_shift; // RULE6
      nbits_q <= last_bit ? 4'h0 : nbits_q + 4'h1;
    end
  end

  // ****************************************
  // Receive FIFO and overrun
  // ****************************************
  // Slot writes: a pop moves slot 1 down, a push lands behind the last kept entry
  // A push never meets a full FIFO, so push with pop always targets slot 0
  wire [1:0] fifo_wr;
  wire [8:0] fifo_in [0:1];
  wire ovr_clr = overrun_error_flag_q && ((!cont && rd_data) || (wr_ctrl && !wb_dat_i[`SSR_CTRL_CONT] && cont)); // RULE14
  assign fifo_wr[0] = pop | (push & (cnt_q == 2'h0));
  assign fifo_wr[1] = push & ~pop & (cnt_q == 2'h1);
  assign fifo_in[0] = push ? next_shift : fifo_q[1];
  assign fifo_in[1] = next_shift;

  // Slots flush while the port enable is clear, as do the fill count and overrun flag
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : g_slot
      always @(posedge clk) begin
        if (reset || !serial_port_enable) begin
          fifo_q[gs] <= 9'h000;
        end else if (fifo_wr[gs]) begin
          fifo_q[gs] <= fifo_in[gs]; // RULE7
        end
      end
    end
  endgenerate

  // Fill count and overrun; an overrun leaves both entries untouched
  always @(posedge clk) begin
    if (reset || !serial_port_enable) begin
      cnt_q <= 2'h0;
      overrun_error_flag_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (ovr_set) begin
        overrun_error_flag_q <= 1'b1; // RULE12
      end else if (ovr_clr) begin
        overrun_error_flag_q <= 1'b0; // RULE14
      end
    end
  end

  // ****************************************
  // Master clock generator
  // ****************************************
  // Clock idles low; leading edge is the rise, trailing the fall out of high
  // Sampling at the end of the high phase leaves the synchronised data settled
  always @(posedge clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      div_q <= 18'h00000;
      clk_out_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          clk_out_q <= 1'b0;
          if (master && rx_on) begin
            st_q <= ST_HIGH;
            div_q <= half_period;
            clk_out_q <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (!(master && rx_on) || abort) begin
            st_q <= ST_IDLE; // RULE4
            clk_out_q <= 1'b0;
          end else if (div_q == 18'h00000) begin
            st_q <= (last_bit && !cont) ? ST_IDLE : ST_LOW; // RULE3
            div_q <= half_period;
            clk_out_q <= 1'b0;
          end else begin
            div_q <= div_q - 18'h00001;
          end
        end
        ST_LOW: begin
          if (!(master && rx_on) || abort) begin
            st_q <= ST_IDLE;
          end else if (div_q == 18'h00000) begin
            st_q <= ST_HIGH;
            div_q <= half_period;
            clk_out_q <= 1'b1;
          end else begin
            div_q <= div_q - 18'h00001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Sticky bits per event; set beats clear in the same cycle so no event is lost
  wire [1:0] irq_evt = {ovr_set, push};
  wire [1:0] irq_clr = (wr & sel_irq_clr) ? wb_dat_i[1:0] : 2'h0;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      always @(posedge clk) begin
        if (reset) begin
          irq_stat_q[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_q[gi] <= 1'b1; // RULE18
        end else if (irq_clr[gi]) begin
          irq_stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Enable register of the same layout
  always @(posedge clk) begin
    if (reset) begin
      irq_en_q <= 2'h0;
    end else if (wr & sel_irq_en) begin
      irq_en_q <= wb_dat_i[1:0];
    end
  end

  // ****************************************
  // Bus answer and pins
  // ****************************************
  // Read word for one offset; unmapped offsets read as zero
  function [31:0] read_word;
    input [5:0] adr;
    begin
      case ({adr[5:2], 2'b00})
        `SSR_OFS_CTRL: read_word = {24'h000000, ctrl_q};
        `SSR_OFS_STAT: read_word = {27'h0000000, cnt_q, cnt_q != 2'h0, overrun_error_flag_q, fifo_q[0][8]}; // RULE8 RULE15
        `SSR_OFS_DATA: read_word = {24'h000000, fifo_q[0][7:0]}; // RULE8
        `SSR_OFS_BAUD: read_word = {16'h0000, baud_q};
        `SSR_OFS_IRQ_STAT: read_word = {30'h00000000, irq_stat_q};
        `SSR_OFS_IRQ_EN: read_word = {30'h00000000, irq_en_q};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  // One-cycle ack latency; read data stands only in the ack cycle
  always @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= read_word(wb_adr_i); // RULE8 RULE15
      end
      irq <= |(irq_stat_q & irq_en_q); // RULE18
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Data is never driven; the clock is gated so it never shows high while released
  always @(posedge clk) begin
    if (reset) begin
      data_pin_o <= 1'b0;
      data_pin_oe <= 1'b0;
      clk_pin_o <= 1'b0;
      clk_pin_oe <= 1'b0;
    end else begin
      data_pin_o <= 1'b0;
      data_pin_oe <= 1'b0; // RULE1
      clk_pin_o <= clk_out_q & active & master;
      clk_pin_oe <= active & master; // RULE9
    end
  end
endmodule // ssr_receiver
`default_nettype wire
